// [ppm_regs.sv]
// Operation
// [RULE1] The frame peak holds the highest PC of the last frame, bits 23:16 and 15:0 in two registers.
// [RULE2] The all-time peak holds the highest PC since the core started, split the same way.
// [RULE3] The clear control register clears both peak monitors to zero.
// [RULE4] Frame peak fields are read-only, reset to zero, upper byte of the high half reads zero.
// [RULE5] All-time peak fields are read-only, reset to zero, upper byte of the high half reads zero.
// [RULE6] A subbank whose ignore bit is 0, its reset value, has its parity errors reported.
// [RULE7] A subbank whose ignore bit is 1 has its parity errors dropped.
// [RULE8] Low-bank ignore register: bits 12:8 bank 1 subbanks 4:0, bits 4:0 bank 0, rest reserved.
// [RULE9] High-bank ignore register: bits 12:8 bank 3, bits 4:0 bank 2, all read-write; the code keeps only bits 12:8 and 4:0, the rest read zero.
// [RULE10] Clear bit 1 clears and freezes the program counter, 0 lets it run.
// [RULE11] Setting then releasing the clear bit resets the all-time peak.
// [RULE12] Unmasked parity errors pass on to panic logic within one clock, masked ones do not.
`timescale 1ns/1ns
`default_nettype none
module ppm_regs (
    input  wire logic                    hclk,          // Core clock
    input  wire logic                    hresetn,       // Async reset, low
    input  wire logic                    hsel,          // Slave select
    input  wire logic [31:0]             haddr,         // Byte address
    input  wire logic [1:0]              htrans,        // Transfer type
    input  wire logic                    hwrite,        // Write when high
    input  wire logic [2:0]              hsize,         // Word only
    input  wire logic [31:0]             hwdata,        // Write data
    input  wire logic                    hready,        // Bus ready in
    output logic [31:0]                  hrdata,        // Read data
    output logic                         hreadyout,     // Slave ready
    output logic                         hresp,         // Always OKAY
    input  wire ppm_pkg::ppm_peak_t      pc_value,      // Core PC
    input  wire logic                    pc_valid,      // PC sample valid
    input  wire logic                    frame_start,   // Frame boundary
    input  wire logic [ppm_pkg::NUM_SUBBANK-1:0] parity_err,    // Raw errors
    output logic [ppm_pkg::NUM_SUBBANK-1:0]      parity_report, // To panic
    output logic                         pc_clear_out,  // Core PC clear
    output logic                         irq            // Level interrupt
);
    import ppm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Flatten the two ignore registers, bank 0 in the low bits
    function automatic logic [NUM_SUBBANK-1:0] ignore_vec(
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        ignore_vec = {hi[12:8], hi[4:0], lo[12:8], lo[4:0]};
    endfunction : ignore_vec

    ppm_phase_t     phase_reg;
    ppm_req_t       req_reg;
    logic           accept;
    logic [15:0]    clear_reg;
    logic [15:0]    mask_lo_reg;
    logic [15:0]    mask_hi_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] enable_reg;
    logic [IRQ_W-1:0] evt_set;
    logic [IRQ_W-1:0] w1c;
    logic [31:0]    rd_next;
    logic           wr_en;
    ppm_peak_t      frame_peak;
    ppm_peak_t      alltime_peak;
    logic           frame_evt;
    logic           alltime_evt;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------

    // Reads insert one wait so the data comes from a flop
    assign accept    = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign hreadyout = (phase_reg != PH_READ);
    assign hresp     = HRESP_OKAY;
    assign wr_en     = (phase_reg == PH_WRITE) & req_reg.hit;

    // Data phase sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= PH_IDLE;
        end else begin
            case (phase_reg)
                PH_READ: begin
                    phase_reg <= PH_READ_OUT;
                end
                PH_IDLE, PH_WRITE, PH_READ_OUT: begin
                    if (accept) phase_reg <= hwrite ? PH_WRITE : PH_READ;
                    else        phase_reg <= PH_IDLE;
                end
                default: begin
                    phase_reg <= PH_IDLE;
                end
            endcase
        end
    end

    // Address phase capture; upper bits must be zero for a hit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg <= '0;
        end else if (accept) begin
            req_reg.idx <= haddr[17:2];
            req_reg.hit <= (haddr[31:18] == 14'h0000);
        end
    end

    // Read mux; unmapped and reserved bits read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (req_reg.hit) begin
            case (req_reg.idx)
                IDX_PC_CLEAR:   rd_next[0]      = clear_reg[CLEAR_BIT];
                IDX_FRAME_HI:   rd_next[7:0]    = frame_peak.high;    // RULE4
                IDX_FRAME_LO:   rd_next[15:0]   = frame_peak.low;     // RULE4
                IDX_ALL_HI:     rd_next[7:0]    = alltime_peak.high;  // RULE5
                IDX_ALL_LO:     rd_next[15:0]   = alltime_peak.low;   // RULE5
                IDX_MASK_LO:    rd_next[15:0]   = mask_lo_reg;
                IDX_MASK_HI:    rd_next[15:0]   = mask_hi_reg;
                IDX_IRQ_STATUS: rd_next[IRQ_W-1:0] = status_reg;
                IDX_IRQ_ENABLE: rd_next[IRQ_W-1:0] = enable_reg;
                default:        rd_next         = 32'h0000_0000;
            endcase
        end
    end

    // Read data register, loaded during the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)                hrdata <= 32'h0000_0000;
        else if (phase_reg == PH_READ) hrdata <= rd_next;
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Clear control; bits 15:1 are not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clear_reg <= REG16_RESET;
        end else if (wr_en && req_reg.idx == IDX_PC_CLEAR) begin
            clear_reg <= {15'h0000, hwdata[CLEAR_BIT]};      // RULE3
        end
    end

    // Level straight from the flop holds the core PC at zero
    assign pc_clear_out = clear_reg[CLEAR_BIT];              // RULE10

    // Ignore masks; reserved gaps stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_lo_reg <= REG16_RESET;
            mask_hi_reg <= REG16_RESET;
        end else if (wr_en) begin
            if (req_reg.idx == IDX_MASK_LO)
                mask_lo_reg <= hwdata[15:0] & MASK_FIELD;    // RULE8
            if (req_reg.idx == IDX_MASK_HI)
                mask_hi_reg <= hwdata[15:0] & MASK_FIELD;    // RULE9
        end
    end

    // ------------------------------------------------------------
    // Parity error filter
    // ------------------------------------------------------------

    // Registered so panic logic sees a clean level, one cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parity_report <= '0;
        end else begin
            parity_report <= parity_err & ~ignore_vec(mask_lo_reg, mask_hi_reg); // RULE6 RULE7 RULE12
        end
    end

    // ------------------------------------------------------------
    // Peak monitors
    // ------------------------------------------------------------

    // Tracker reads the clear level so both peaks zero together
    ppm_peak_track u_track (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .pc_clear     (clear_reg[CLEAR_BIT]),
        .pc_valid     (pc_valid),
        .pc_value     (pc_value),
        .frame_start  (frame_start),
        .frame_peak   (frame_peak),
        .alltime_peak (alltime_peak),
        .frame_evt    (frame_evt),
        .alltime_evt  (alltime_evt)
    );

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------

    assign evt_set[IRQ_FRAME]  = frame_evt;
    assign evt_set[IRQ_PEAK]   = alltime_evt;
    assign evt_set[IRQ_PARITY] = |parity_report;

    // Write one to clear
    assign w1c = (wr_en && req_reg.idx == IDX_IRQ_STATUS) ? hwdata[IRQ_W-1:0] : '0;

    // Set beats clear so a coinciding event is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) status_reg <= '0;
        else          status_reg <= (status_reg & ~w1c) | evt_set;
    end

    // Enable register, 1 lets the bit reach irq
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            enable_reg <= '0;
        else if (wr_en && req_reg.idx == IDX_IRQ_ENABLE)
            enable_reg <= hwdata[IRQ_W-1:0];
    end

    assign irq = |(status_reg & enable_reg);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    property p_frame_latch;
        @(posedge hclk) disable iff (!hresetn)
        (frame_start && !clear_reg[CLEAR_BIT])
        |=> frame_peak == $past(u_track.run_reg);
    endproperty
    a_frame_latch: assert property (p_frame_latch) // RULE1
        else $error("frame peak did not latch the running peak");

    property p_alltime_mono;
        @(posedge hclk) disable iff (!hresetn)
        (!clear_reg[CLEAR_BIT] ##1 !clear_reg[CLEAR_BIT])
        |-> alltime_peak >= $past(alltime_peak);
    endproperty
    a_alltime_mono: assert property (p_alltime_mono) // RULE2
        else $error("all-time peak fell without a clear");

    property p_clear_zero;
        @(posedge hclk) disable iff (!hresetn)
        clear_reg[CLEAR_BIT] |=> (frame_peak == '0) && (alltime_peak == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) // RULE3
        else $error("peaks not zero while clear is held");

    property p_frame_hi_read;
        @(posedge hclk) disable iff (!hresetn)
        (phase_reg == PH_READ && req_reg.hit && req_reg.idx == IDX_FRAME_HI)
        |=> hrdata == {24'h000000, $past(frame_peak.high)} && hreadyout;
    endproperty
    a_frame_hi_read: assert property (p_frame_hi_read) // RULE4
        else $error("frame high read wrong");

    property p_all_lo_read;
        @(posedge hclk) disable iff (!hresetn)
        (phase_reg == PH_READ && req_reg.hit && req_reg.idx == IDX_ALL_LO)
        |=> hrdata == {16'h0000, $past(alltime_peak.low)};
    endproperty
    a_all_lo_read: assert property (p_all_lo_read) // RULE5
        else $error("all-time low read wrong");

    property p_report;
        @(posedge hclk) disable iff (!hresetn)
        (parity_err[0] && !mask_lo_reg[0]) |=> parity_report[0];
    endproperty
    a_report: assert property (p_report) // RULE6
        else $error("unmasked parity error not reported");

    property p_ignore;
        @(posedge hclk) disable iff (!hresetn)
        mask_hi_reg[12] |=> !parity_report[NUM_SUBBANK-1];
    endproperty
    a_ignore: assert property (p_ignore) // RULE7
        else $error("masked parity error reported");

    property p_mask_lo_wr;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && req_reg.idx == IDX_MASK_LO)
        |=> {mask_lo_reg[12:8], mask_lo_reg[4:0]}
            == {$past(hwdata[12:8]), $past(hwdata[4:0])};
    endproperty
    a_mask_lo_wr: assert property (p_mask_lo_wr) // RULE8
        else $error("low-bank mask write lost");

    property p_mask_hi_wr;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && req_reg.idx == IDX_MASK_HI)
        |=> mask_hi_reg == ($past(hwdata[15:0]) & MASK_FIELD);
    endproperty
    a_mask_hi_wr: assert property (p_mask_hi_wr) // RULE9
        else $error("high-bank mask write lost");

    property p_clear_out;
        @(posedge hclk) disable iff (!hresetn)
        (wr_en && req_reg.idx == IDX_PC_CLEAR)
        |=> pc_clear_out == $past(hwdata[0]);
    endproperty
    a_clear_out: assert property (p_clear_out) // RULE10
        else $error("clear output does not follow write");

    property p_release;
        @(posedge hclk) disable iff (!hresetn)
        $fell(clear_reg[CLEAR_BIT]) |=> alltime_peak == '0;
    endproperty
    a_release: assert property (p_release) // RULE11
        else $error("all-time peak not reset on release");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        (|parity_report && enable_reg[IRQ_PARITY]) |=> irq;
    endproperty
    a_irq: assert property (p_irq) // RULE12
        else $error("parity interrupt missing");

    // Main scenarios
    property p_cov_read;
        @(posedge hclk) disable iff (!hresetn)
        phase_reg == PH_READ ##1 phase_reg == PH_READ_OUT;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_release;
        @(posedge hclk) disable iff (!hresetn)
        $fell(clear_reg[CLEAR_BIT]);
    endproperty
    c_cov_release: cover property (p_cov_release);

    property p_cov_frame;
        @(posedge hclk) disable iff (!hresetn)
        frame_evt && frame_peak != '0;
    endproperty
    c_cov_frame: cover property (p_cov_frame);

    property p_cov_irq;
        @(posedge hclk) disable iff (!hresetn)
        irq ##1 !irq;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

endmodule : ppm_regs
`default_nettype wire

// [ppm_pkg.sv]
`default_nettype none
package ppm_pkg;

    // ------------------------------------------------------------
    // Register word indices (byte address = 4 x index)
    // ------------------------------------------------------------
    localparam int unsigned IDX_W          = 16;
    localparam logic [15:0] IDX_PC_CLEAR   = 16'hF462;
    localparam logic [15:0] IDX_FRAME_HI   = 16'hF463;
    localparam logic [15:0] IDX_FRAME_LO   = 16'hF464;
    localparam logic [15:0] IDX_ALL_HI     = 16'hF465;
    localparam logic [15:0] IDX_ALL_LO     = 16'hF466;
    localparam logic [15:0] IDX_MASK_LO    = 16'hF467;
    localparam logic [15:0] IDX_MASK_HI    = 16'hF468;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hF470;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF471;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_FIELD     = 16'h1F1F;
    localparam logic [15:0] REG16_RESET    = 16'h0000;
    localparam int unsigned CLEAR_BIT      = 0;
    localparam int unsigned NUM_SUBBANK    = 20;
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_FRAME      = 0;
    localparam int unsigned IRQ_PEAK       = 1;
    localparam int unsigned IRQ_PARITY     = 2;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  high;
        logic [15:0] low;
    } ppm_peak_t;

    typedef struct packed {
        logic        hit;
        logic [15:0] idx;
    } ppm_req_t;

    typedef enum {PH_IDLE, PH_WRITE, PH_READ, PH_READ_OUT} ppm_phase_t;

endpackage : ppm_pkg
`default_nettype wire

// [ppm_peak_track.sv]
`timescale 1ns/1ns
`default_nettype none
module ppm_peak_track (
    input  wire logic              hclk,         // Core clock
    input  wire logic              hresetn,      // Async reset, low
    input  wire logic              pc_clear,     // Clear control level
    input  wire logic              pc_valid,     // Sample of pc_value valid
    input  wire ppm_pkg::ppm_peak_t pc_value,    // Current program counter
    input  wire logic              frame_start,  // Frame or block boundary
    output ppm_pkg::ppm_peak_t     frame_peak,   // Peak of last frame
    output ppm_pkg::ppm_peak_t     alltime_peak, // Peak since start
    output logic                   frame_evt,    // Frame peak latched
    output logic                   alltime_evt   // All-time peak raised
);
    import ppm_pkg::*;

    ppm_peak_t run_reg;
    logic      clr_d_reg;
    logic      release_clr;

    // Release of the clear bit restarts the all-time history
    assign release_clr = clr_d_reg & ~pc_clear;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) clr_d_reg <= 1'b0;
        else          clr_d_reg <= pc_clear;
    end

    // ------------------------------------------------------------
    // Running peak of the frame in progress
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= '0;
        end else if (pc_clear) begin
            run_reg <= '0;                                 // RULE3
        end else if (frame_start) begin
            run_reg <= pc_valid ? pc_value : ppm_peak_t'('0);
        end else if (pc_valid && pc_value > run_reg) begin
            run_reg <= pc_value;
        end
    end

    // Boundary sample belongs to the new frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_peak <= '0;
            frame_evt  <= 1'b0;
        end else begin
            frame_evt <= frame_start & ~pc_clear;
            if (pc_clear)         frame_peak <= '0;          // RULE3
            else if (frame_start) frame_peak <= run_reg;     // RULE1
        end
    end

    // All-time peak; cleared while held and again on release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alltime_peak <= '0;
            alltime_evt  <= 1'b0;
        end else begin
            alltime_evt <= 1'b0;
            if (pc_clear || release_clr) begin
                alltime_peak <= '0;                          // RULE11
            end else if (pc_valid && pc_value > alltime_peak) begin
                alltime_peak <= pc_value;                    // RULE2
                alltime_evt  <= 1'b1;
            end
        end
    end

endmodule : ppm_peak_track
`default_nettype wire

// [pc_peak_monitor_parity_mask_test.sv]
`timescale 1ns/1ns
`default_nettype none
module pc_peak_monitor_parity_mask_test;
    import ppm_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        pc_valid, frame_start, pc_clear_out, irq;
    logic        rdy_q, rd_dp, clr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [31:0] seed = 32'h29D1;
    logic [23:0] v, fmax, amax, fpk;
    logic [15:0] mlo, mhi;
    logic [19:0] parity_err, parity_report, ign;
    logic [15:0] regs [9];
    logic [31:0] exp_q [$];
    ppm_peak_t   pc_value;
    int          miscompares, check_count;

    ppm_regs u_ppm_regs (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pc_value(pc_value), .pc_valid(pc_valid),
        .frame_start(frame_start), .parity_err(parity_err), .parity_report(parity_report),
        .pc_clear_out(pc_clear_out), .irq(irq)
    );

    // ------------------------------------------------------------
    // Clock, helpers and bus master
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Single word transfer; for a read, d is the expected word
    task automatic xfer(bit w, logic [15:0] idx, logic [31:0] d);
        haddr <= {14'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge hclk); while (rdy_q !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        if (w) hwdata <= d;
        else exp_q.push_back(d);
        do @(posedge hclk); while (rdy_q !== 1'b1);
    endtask : xfer

    // Read monitor at mid-cycle, where the slave outputs have settled
    always @(negedge hclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk("hrdata", exp_q.pop_front(), hrdata);
            chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
        end
        if (hreadyout === 1'b1) rd_dp = hsel && htrans == HTRANS_NONSEQ && !hwrite;
        rdy_q = hreadyout;
    end

    task automatic lv(logic ec, logic ei);
        @(negedge hclk);
        chk("pc_clear_out", 32'(ec), 32'(pc_clear_out));
        chk("irq", 32'(ei), 32'(irq));
        @(posedge hclk);
    endtask : lv

    // Report is registered, so it is checked one edge after the error
    task automatic par(logic [19:0] e);
        parity_err <= e;
        @(posedge hclk);
        @(negedge hclk);
        chk("parity_report", 32'(e & ~ign), 32'(parity_report));
        @(posedge hclk);
    endtask : par

    task automatic masks(logic [31:0] lo, logic [31:0] hi);
        xfer(1, IDX_MASK_LO, lo);
        xfer(1, IDX_MASK_HI, hi);
        mlo = lo[15:0] & MASK_FIELD;
        mhi = hi[15:0] & MASK_FIELD;
        ign = {mhi[12:8], mhi[4:0], mlo[12:8], mlo[4:0]};
    endtask : masks

    // Program counter samples; top sets bit 23 so one frame outranks another
    task automatic pcs(int n, logic top);
        repeat (n) begin
            r = xs();
            v = {top, r[22:0]};
            pc_value <= v;
            pc_valid <= 1'b1;
            if (!clr && v > fmax) fmax = v;
            if (!clr && v > amax) amax = v;
            @(posedge hclk);
        end
        pc_valid <= 1'b0;
    endtask : pcs

    task automatic frm();
        frame_start <= 1'b1;
        @(posedge hclk);
        frame_start <= 1'b0;
        fpk = fmax;
        fmax = '0;
        repeat (2) @(posedge hclk);
    endtask : frm

    task automatic pk_chk();
        xfer(0, IDX_FRAME_HI, {24'h0, fpk[23:16]});
        xfer(0, IDX_FRAME_LO, {16'h0, fpk[15:0]});
        xfer(0, IDX_ALL_HI, {24'h0, amax[23:16]});
        xfer(0, IDX_ALL_LO, {16'h0, amax[15:0]});
    endtask : pk_chk

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, pc_valid, frame_start, clr, rd_dp} = '0;
        {haddr, hwdata, htrans, pc_value, parity_err, fmax, amax, fpk} = '0;
        {mlo, mhi, ign} = '0;
        hsize = 3'b010;
        rdy_q = 1'b1;
        regs = '{IDX_PC_CLEAR, IDX_FRAME_HI, IDX_FRAME_LO, IDX_ALL_HI, IDX_ALL_LO,
                 IDX_MASK_LO, IDX_MASK_HI, IDX_IRQ_STATUS, 16'hF46F};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, including an unmapped word
        foreach (regs[i]) xfer(0, regs[i], 32'h0);
        // Read-only words ignore writes; reserved mask bits are not kept
        xfer(1, IDX_FRAME_HI, 32'hFFFF);
        xfer(1, IDX_ALL_LO, 32'hFFFF);
        masks(32'hFFFFFFFF, xs());
        xfer(0, IDX_MASK_LO, {16'h0, mlo});
        xfer(0, IDX_MASK_HI, {16'h0, mhi});
        xfer(0, IDX_FRAME_HI, 32'h0);
        xfer(0, IDX_ALL_LO, 32'h0);
        // Parity filtering with random, full and empty masks
        masks(xs(), xs());
        repeat (6) par(20'(xs()));
        masks(32'h1F1F, 32'h1F1F);
        par(20'hFFFFF);
        masks(32'h0, 32'h0);
        par(20'hFFFFF);
        par(20'h0);
        // Two frames, the second lower than the first
        pcs(6, 1'b1);
        frm();
        pk_chk();
        pcs(6, 1'b0);
        frm();
        pk_chk();
        // Clear held: peaks zero and samples ignored
        xfer(1, IDX_PC_CLEAR, 32'h1);
        {clr, fmax, amax, fpk} = '0;
        clr = 1'b1;
        lv(1'b1, 1'b0);
        pcs(4, 1'b1);
        frm();
        pk_chk();
        xfer(0, IDX_PC_CLEAR, 32'h1);
        xfer(1, IDX_PC_CLEAR, 32'h0);
        clr = 1'b0;
        lv(1'b0, 1'b0);
        pk_chk();
        pcs(3, 1'b0);
        frm();
        pk_chk();
        // Interrupt: sticky status, enable and write-one-to-clear
        xfer(0, IDX_IRQ_STATUS, 32'h7);
        xfer(1, IDX_IRQ_ENABLE, 32'h7);
        lv(1'b0, 1'b1);
        xfer(1, IDX_IRQ_STATUS, 32'h3);
        xfer(0, IDX_IRQ_STATUS, 32'h4);
        lv(1'b0, 1'b1);
        xfer(1, IDX_IRQ_STATUS, 32'h4);
        lv(1'b0, 1'b0);
        // An unmasked parity error raises the enabled interrupt
        par(20'h00010);
        par(20'h00000);
        lv(1'b0, 1'b1);
        xfer(1, IDX_IRQ_STATUS, 32'h4);
        lv(1'b0, 1'b0);
        frm();
        lv(1'b0, 1'b1);
        xfer(1, IDX_IRQ_ENABLE, 32'h0);
        lv(1'b0, 1'b0);
        xfer(0, IDX_IRQ_STATUS, 32'h1);
        xfer(0, IDX_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge hclk);
        report_and_stop();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        report_and_stop();
    end
endmodule : pc_peak_monitor_parity_mask_test
`default_nettype wire
